// >>> pkg/xmb_pkg.sv
// package for the external memory bus block
// assumes one 40 MHz clock and an active-low asynchronous reset
package xmb_pkg;
    localparam int ADDR_W     = 20;
    localparam int ADDR_LO_W  = 16;
    localparam int DATA_W     = 16;
    localparam int WAIT_W     = 3;
    localparam logic [WAIT_W-1:0] WAIT_RDY_MIN = 3'h2;
    localparam logic [WAIT_W-1:0] WAIT_ONE     = 3'h1;
    localparam logic [WAIT_W-1:0] WAIT_RESET   = 3'h7;
    localparam logic              KEEP_RESET   = 1'b0;
    localparam logic [ADDR_W-1:0] ADDR_RESET   = 20'h0_0000;
    localparam logic [DATA_W-1:0] DATA_RESET   = 16'h0000;
    typedef enum logic [1:0] {
        XMB_SP_PROG,
        XMB_SP_DATA,
        XMB_SP_IO
    } xmb_space_t;
    typedef enum {
        XMB_IDLE,
        XMB_SWAIT,
        XMB_RWAIT,
        XMB_LAST,
        XMB_HOLD
    } xmb_state_t;
endpackage

// >>> pkg/xmb_sync_if.sv
// carries raw pin levels into the synchroniser and clean levels out
// assumes both ends share mclk_i
`timescale 1ns/1ps
`default_nettype none
interface xmb_sync_if;
    logic ready_raw;
    logic hold_raw;
    logic off_raw;
    logic ready_s;
    logic hold_s;
    logic off_s;
    modport top  (output ready_raw, hold_raw, off_raw,
                  input  ready_s, hold_s, off_s);
    modport sync (input  ready_raw, hold_raw, off_raw,
                  output ready_s, hold_s, off_s);
endinterface
`default_nettype wire

// >>> hw/xmb_sync.sv
// two-flop synchronisers for the asynchronous bus pins
// assumes raw levels come straight from pins
`timescale 1ns/1ps
`default_nettype none
module xmb_sync (
    input  wire logic mclk_i,
    input  wire logic rstn_i,
    xmb_sync_if.sync  s
);
    logic [2:0] meta_q, meta_d;
    logic [2:0] sync_q, sync_d;
    always_comb begin
        meta_d = {s.off_raw, s.hold_raw, s.ready_raw};
        sync_d = meta_q;
    end
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_q <= 3'h6;
            sync_q <= 3'h6;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end
    assign s.ready_s = sync_q[0];
    assign s.hold_s  = sync_q[1];
    assign s.off_s   = sync_q[2];
endmodule // xmb_sync
`default_nettype wire

// >>> hw/xmb_bus.sv
// external memory bus of the signal processor: address, data, selects,
// strobes, wait states, hold and the outputs-off condition
// assumes the core holds req_i with stable fields until done_o pulses
`timescale 1ns/1ps
`default_nettype none
module xmb_bus (
    input  wire logic                         mclk_i,
    input  wire logic                         rstn_i,
    input  wire logic                         req_i,
    input  wire xmb_pkg::xmb_space_t          space_i,
    input  wire logic                         write_i,
    input  wire logic                         fetch_i,
    input  wire logic                         vector_i,
    input  wire logic [xmb_pkg::ADDR_W-1:0]   addr_i,
    input  wire logic [xmb_pkg::DATA_W-1:0]   wdata_i,
    input  wire logic [xmb_pkg::WAIT_W-1:0]   wait_states_i,
    input  wire logic                         bus_keeper_enable_i,
    output logic                              done_o,
    output logic [xmb_pkg::DATA_W-1:0]        rdata_o,
    input  wire logic                         ready_i,
    input  wire logic                         hold_req_n_i,
    input  wire logic                         test_reset_i,
    input  wire logic                         emulation_pin_zero_i,
    input  wire logic                         outputs_off_n_i,
    output logic [xmb_pkg::ADDR_W-1:0]        addr_o,
    output logic                              addr_oe_o,
    input  wire logic [xmb_pkg::DATA_W-1:0]   data_i,
    output logic [xmb_pkg::DATA_W-1:0]        data_o,
    output logic                              data_oe_o,
    output logic                              data_keep_o,
    output logic                              program_space_select_n_o,
    output logic                              data_space_select_n_o,
    output logic                              io_space_select_n_o,
    output logic                              memory_strobe_n_o,
    output logic                              io_strobe_n_o,
    output logic                              rd_wr_n_o,
    output logic                              bus_grant_n_o,
    output logic                              wait_states_done_n_o,
    output logic                              instr_fetch_n_o,
    output logic                              irq_vector_fetch_n_o,
    output logic                              machine_clock_out_o,
    output logic                              ctrl_oe_o
);
    import xmb_pkg::*;

    xmb_sync_if sif ();
    assign sif.ready_raw = ready_i;
    assign sif.hold_raw  = hold_req_n_i;
    assign sif.off_raw   = outputs_off_n_i;
    xmb_sync u_sync (
        .mclk_i (mclk_i),
        .rstn_i (rstn_i),
        .s      (sif)
    );

    // test reset and emulation pin are static straps, still synchronised
    logic [1:0] strap_m_q, strap_m_d, strap_q, strap_d;

    xmb_state_t          st_q, st_d;
    logic [WAIT_W-1:0]   cnt_q, cnt_d;
    logic [WAIT_W-1:0]   nws_q, nws_d;
    logic [ADDR_W-1:0]   addr_q, addr_d;
    logic [DATA_W-1:0]   wdat_q, wdat_d;
    logic [DATA_W-1:0]   rdat_q, rdat_d;
    xmb_space_t          sp_q, sp_d;
    logic                wr_q, wr_d, fet_q, fet_d, vec_q, vec_d;
    logic                done_q, done_d;
    logic                msc_q, msc_d;
    logic                mclk_q, mclk_d;
    logic                keep_q, keep_d;
    logic                grant_q, grant_d;
    logic                aoe_q, aoe_d, doe_q, doe_d, coe_q, coe_d;
    logic                ps_q, ps_d, ds_q, ds_d, is_q, is_d;
    logic                ms_q, ms_d, ios_q, ios_d, rw_q, rw_d;
    logic                iaq_q, iaq_d, irq_vector_fetch_n_q, irq_vector_fetch_n_d;
    logic                off_act, busy;

    function automatic logic [ADDR_W-1:0] ext_addr(
        input logic [ADDR_W-1:0] a, input xmb_space_t s);
        logic [ADDR_W-1:0] r;
        r = a;
        if (s != XMB_SP_PROG)
            r[ADDR_W-1:ADDR_LO_W] = '0;
        return r;
    endfunction

    always_comb begin
        strap_m_d = {emulation_pin_zero_i, test_reset_i};
        strap_d   = strap_m_q;
    end

    assign off_act = !sif.off_s && !strap_q[0] && strap_q[1];

    always_comb begin
        st_d    = st_q;
        cnt_d   = cnt_q;
        nws_d   = nws_q;
        addr_d  = addr_q;
        wdat_d  = wdat_q;
        rdat_d  = rdat_q;
        sp_d    = sp_q;
        wr_d    = wr_q;
        fet_d   = fet_q;
        vec_d   = vec_q;
        done_d  = 1'b0;
        msc_d   = msc_q;
        grant_d = grant_q;
        case (st_q)
            XMB_IDLE: begin
                msc_d   = 1'b1;
                grant_d = 1'b1;
                if (!sif.hold_s) begin
                    st_d = XMB_HOLD;
                end else if (req_i) begin
                    addr_d = ext_addr(addr_i, space_i);
                    wdat_d = wdata_i;
                    sp_d   = space_i;
                    wr_d   = write_i;
                    fet_d  = fetch_i;
                    vec_d  = vector_i;
                    nws_d  = wait_states_i;
                    cnt_d  = wait_states_i;
                    if (wait_states_i == '0) begin
                        st_d = XMB_LAST;
                    end else begin
                        st_d  = XMB_SWAIT;
                        msc_d = (wait_states_i < WAIT_RDY_MIN);
                    end
                end
            end
            XMB_SWAIT: begin
                cnt_d = cnt_q - WAIT_ONE;
                if (cnt_q == WAIT_RDY_MIN)
                    msc_d = 1'b1;
                if (cnt_q == WAIT_ONE) begin
                    st_d = (nws_q >= WAIT_RDY_MIN) ? XMB_RWAIT : XMB_LAST;
                end
            end
            XMB_RWAIT: begin
                if (sif.ready_s)
                    st_d = XMB_LAST;
            end
            XMB_LAST: begin
                if (!wr_q)
                    rdat_d = data_i;
                done_d = 1'b1;
                st_d   = XMB_IDLE;
            end
            XMB_HOLD: begin
                grant_d = 1'b0;
                if (sif.hold_s) begin
                    grant_d = 1'b1;
                    st_d    = XMB_IDLE;
                end
            end
            default: st_d = XMB_IDLE;
        endcase
    end

    assign busy = (st_d == XMB_SWAIT) || (st_d == XMB_RWAIT) ||
                  (st_d == XMB_LAST);

    always_comb begin
        mclk_d = !mclk_q;
        keep_d = bus_keeper_enable_i;
        aoe_d  = !off_act && (st_d != XMB_HOLD);
        coe_d  = !off_act;
        doe_d  = !off_act && busy && wr_d && sif.hold_s;
        ps_d   = !(busy && sp_d == XMB_SP_PROG);
        ds_d   = !(busy && sp_d == XMB_SP_DATA);
        is_d   = !(busy && sp_d == XMB_SP_IO);
        ms_d   = !(busy && sp_d != XMB_SP_IO);
        ios_d  = !(busy && sp_d == XMB_SP_IO);
        rw_d   = !(busy && wr_d);
        iaq_d  = !(busy && fet_d);
        irq_vector_fetch_n_d = !(busy && vec_d);
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            strap_m_q <= 2'h0;
            strap_q   <= 2'h0;
            st_q      <= XMB_IDLE;
            cnt_q     <= '0;
            nws_q     <= WAIT_RESET;
            addr_q    <= ADDR_RESET;
            wdat_q    <= DATA_RESET;
            rdat_q    <= DATA_RESET;
            sp_q      <= XMB_SP_PROG;
            wr_q      <= 1'b0;
            fet_q     <= 1'b0;
            vec_q     <= 1'b0;
            done_q    <= 1'b0;
            msc_q     <= 1'b1;
            mclk_q    <= 1'b0;
            keep_q    <= KEEP_RESET;
            grant_q   <= 1'b1;
            aoe_q     <= 1'b0;
            doe_q     <= 1'b0;
            coe_q     <= 1'b0;
            ps_q      <= 1'b1;
            ds_q      <= 1'b1;
            is_q      <= 1'b1;
            ms_q      <= 1'b1;
            ios_q     <= 1'b1;
            rw_q      <= 1'b1;
            iaq_q     <= 1'b1;
            irq_vector_fetch_n_q    <= 1'b1;
        end else begin
            strap_m_q <= strap_m_d;
            strap_q   <= strap_d;
            st_q      <= st_d;
            cnt_q     <= cnt_d;
            nws_q     <= nws_d;
            addr_q    <= addr_d;
            wdat_q    <= wdat_d;
            rdat_q    <= rdat_d;
            sp_q      <= sp_d;
            wr_q      <= wr_d;
            fet_q     <= fet_d;
            vec_q     <= vec_d;
            done_q    <= done_d;
            msc_q     <= msc_d;
            mclk_q    <= mclk_d;
            keep_q    <= keep_d;
            grant_q   <= grant_d;
            aoe_q     <= aoe_d;
            doe_q     <= doe_d;
            coe_q     <= coe_d;
            ps_q      <= ps_d;
            ds_q      <= ds_d;
            is_q      <= is_d;
            ms_q      <= ms_d;
            ios_q     <= ios_d;
            rw_q      <= rw_d;
            iaq_q     <= iaq_d;
            irq_vector_fetch_n_q    <= irq_vector_fetch_n_d;
        end
    end

    assign done_o                   = done_q;
    assign rdata_o                  = rdat_q;
    assign addr_o                   = addr_q;
    assign addr_oe_o                = aoe_q;
    assign data_o                   = wdat_q;
    assign data_oe_o                = doe_q;
    assign data_keep_o              = keep_q;
    assign program_space_select_n_o = ps_q;
    assign data_space_select_n_o    = ds_q;
    assign io_space_select_n_o      = is_q;
    assign memory_strobe_n_o        = ms_q;
    assign io_strobe_n_o            = ios_q;
    assign rd_wr_n_o                = rw_q;
    assign bus_grant_n_o            = grant_q;
    assign wait_states_done_n_o     = msc_q;
    assign instr_fetch_n_o          = iaq_q;
    assign irq_vector_fetch_n_o     = irq_vector_fetch_n_q;
    assign machine_clock_out_o      = mclk_q;
    assign ctrl_oe_o                = coe_q;
endmodule // xmb_bus
`default_nettype wire

// >>> tb/xmb_bus_properties.sv
// concurrent checks on the external memory bus ports
// assumes one clock mclk_i and active-low reset rstn_i
`timescale 1ns/1ps
`default_nettype none
module xmb_bus_props (
    input wire logic       mclk_i,
    input wire logic       rstn_i,
    input wire logic       req_i,
    input wire logic [2:0] wait_states_i,
    input wire logic       hold_req_n_i,
    input wire logic       test_reset_i,
    input wire logic       emulation_pin_zero_i,
    input wire logic       outputs_off_n_i,
    input wire logic       done_o,
    input wire logic       addr_oe_o,
    input wire logic       data_oe_o,
    input wire logic       program_space_select_n_o,
    input wire logic       data_space_select_n_o,
    input wire logic       io_space_select_n_o,
    input wire logic       memory_strobe_n_o,
    input wire logic       io_strobe_n_o,
    input wire logic       rd_wr_n_o,
    input wire logic       bus_grant_n_o,
    input wire logic       wait_states_done_n_o,
    input wire logic       ctrl_oe_o
);
    import xmb_pkg::*;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    wire logic acc = !(memory_strobe_n_o && io_strobe_n_o);
    wire logic [2:0] sel = {program_space_select_n_o,
        data_space_select_n_o, io_space_select_n_o};
    sequence s_take; $rose(req_i) && hold_req_n_i && bus_grant_n_o; endsequence
    sequence s_off;
        (!outputs_off_n_i && !test_reset_i && emulation_pin_zero_i)[*4];
    endsequence
    property p_adr; !bus_grant_n_o |-> !addr_oe_o; endproperty
    a_adr: assert property (p_adr)
        else $error("address driven in hold");
    property p_dat; data_oe_o |-> !rd_wr_n_o && acc; endproperty
    a_dat: assert property (p_dat)
        else $error("data driven outside a write");
    property p_sel; sel != 3'h7 |-> addr_oe_o && $onehot0(~sel); endproperty
    a_sel: assert property (p_sel)
        else $error("space selects wrong");
    property p_ms; !memory_strobe_n_o |-> sel == 3'h3 || sel == 3'h5;
    endproperty
    a_ms: assert property (p_ms)
        else $error("memory strobe without memory space");
    property p_io; !io_strobe_n_o |-> sel == 3'h6; endproperty
    a_io: assert property (p_io)
        else $error("io strobe without io space");
    property p_rw; !rd_wr_n_o |-> acc; endproperty
    a_rw: assert property (p_rw)
        else $error("write direction outside access");
    property p_hld; !bus_grant_n_o |-> !data_oe_o && !acc; endproperty
    a_hld: assert property (p_hld)
        else $error("bus busy while granted");
    property p_off; s_off |-> !ctrl_oe_o && !addr_oe_o && !data_oe_o;
    endproperty
    a_off: assert property (p_off)
        else $error("outputs driven while off");
    property p_msc; !wait_states_done_n_o |-> acc; endproperty
    a_msc: assert property (p_msc)
        else $error("wait-done low outside access");
    property p_fast; s_take ##0 wait_states_i < WAIT_RDY_MIN |-> ##[2:3] done_o;
    endproperty
    a_fast: assert property (p_fast)
        else $error("short access late");
    property p_slow; s_take ##0 wait_states_i >= WAIT_RDY_MIN |-> !done_o[*5];
    endproperty
    a_slow: assert property (p_slow)
        else $error("long access ended early");
endmodule // xmb_bus_props
bind xmb_bus xmb_bus_props i_props (.*);
`default_nettype wire

// >>> tb/xmb_mem_model.sv
// memory and io device model on the far side of the bus
// assumes the bench resolves nothing else on the data wire
`timescale 1ns/1ps
`default_nettype none
module xmb_mem_model (
    input  wire logic        mclk_i,
    input  wire logic [1:0]  mode_i,
    input  wire logic [7:0]  lag_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        drive_i,
    input  wire logic        keep_i,
    input  wire logic        mem_n_i,
    input  wire logic        io_n_i,
    input  wire logic        rd_i,
    input  wire logic        msc_n_i,
    output logic             ready_o,
    output logic [15:0]      data_o
);
    logic [15:0] mem [256];
    logic [15:0] last = 16'h0000;
    logic [7:0]  cnt = 8'h00;
    wire  logic  sel = !(mem_n_i && io_n_i);
    always_ff @(posedge mclk_i) begin
        cnt <= sel ? cnt + 8'h01 : 8'h00;
        last <= data_o;
        if (sel && drive_i && !rd_i) mem[addr_i[7:0]] <= wdata_i;
    end
    always_comb begin
        case (mode_i)
            2'h0: ready_o = 1'b1;
            2'h1: ready_o = sel && cnt >= lag_i;
            default: ready_o = msc_n_i;
        endcase
        if (drive_i) data_o = wdata_i;
        else if (sel && rd_i) data_o = mem[addr_i[7:0]];
        else if (keep_i) data_o = last;
        else data_o = ~last;
    end
endmodule // xmb_mem_model
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the external memory bus block
// assumes the memory model answers on the far side of the bus
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import xmb_pkg::*;
    logic              mclk_i, rstn_i, req_i, write_i, fetch_i, vector_i;
    logic              bus_keeper_enable_i, ready_i, hold_req_n_i;
    logic              test_reset_i, emulation_pin_zero_i, outputs_off_n_i;
    logic              done_o, addr_oe_o, data_oe_o, data_keep_o, rd_wr_n_o;
    logic              program_space_select_n_o, data_space_select_n_o;
    logic              io_space_select_n_o, memory_strobe_n_o, io_strobe_n_o;
    logic              bus_grant_n_o, wait_states_done_n_o, instr_fetch_n_o;
    logic              irq_vector_fetch_n_o, machine_clock_out_o, ctrl_oe_o;
    xmb_space_t        space_i;
    logic [ADDR_W-1:0] addr_i, addr_o;
    logic [DATA_W-1:0] wdata_i, rdata_o, data_i, data_o;
    logic [WAIT_W-1:0] wait_states_i;
    logic [1:0]        mode;
    logic [7:0]        lag;
    int                num_errors = 0, total_checks = 0, cycles = 0, lat, rl;
    xmb_bus i_dut (.*);
    xmb_mem_model i_mem (.mclk_i, .mode_i(mode), .lag_i(lag),
        .addr_i(addr_o[15:0]), .wdata_i(data_o), .drive_i(data_oe_o),
        .keep_i(data_keep_o), .mem_n_i(memory_strobe_n_o),
        .io_n_i(io_strobe_n_o), .rd_i(rd_wr_n_o),
        .msc_n_i(wait_states_done_n_o), .ready_o(ready_i), .data_o(data_i));
    initial begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            wrap_up();
        end
    end
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic access(xmb_space_t sp, logic wr, logic f, logic v,
                          logic [19:0] a, logic [15:0] wd, logic [2:0] ws);
        logic seen, wait_states_done_n;
        seen = 1'b0;
        wait_states_done_n = 1'b0;
        lat = 0;
        tick(1);
        space_i = sp;
        {write_i, fetch_i, vector_i, addr_i, wdata_i} = {wr, f, v, a, wd};
        wait_states_i = ws;
        req_i = 1'b1;
        while (done_o !== 1'b1 && lat < 200) begin
            tick(1);
            lat++;
            if (!wait_states_done_n_o) wait_states_done_n = 1'b1;
            if (!seen && !(memory_strobe_n_o && io_strobe_n_o)) begin
                seen = 1'b1;
                check("addr", addr_o, sp == XMB_SP_PROG ? a : a[15:0]);
                check("selects", {program_space_select_n_o,
                    data_space_select_n_o, io_space_select_n_o},
                    3'h7 ^ (3'h4 >> sp));
                check("strobes", {memory_strobe_n_o, io_strobe_n_o},
                    sp == XMB_SP_IO ? 2'h2 : 2'h1);
                check("dir fetch vec oe", {rd_wr_n_o, instr_fetch_n_o,
                    irq_vector_fetch_n_o, data_oe_o},
                    {!wr, !f, !v, wr});
            end
        end
        check("done", done_o, 1'b1);
        check("wait-done", wait_states_done_n, ws >= WAIT_RDY_MIN);
        req_i = 1'b0;
    endtask
    task automatic t_rw();
        for (int s = 0; s < 3; s++) begin
            access(xmb_space_t'(s), 1'b1, 1'b0, 1'b0, 20'hF_0010 + s,
                   16'hA5C0 + s, 3'(s));
            access(xmb_space_t'(s), 1'b0, 1'b0, 1'b0, 20'hF_0010 + s,
                   16'h0000, 3'h2);
            check("rdata", rdata_o, 16'hA5C0 + s);
        end
        access(XMB_SP_PROG, 1'b0, 1'b1, 1'b0, 20'hA_BC10, 16'h0000, 3'h0);
        check("fetch rdata", rdata_o, 16'hA5C0);
        access(XMB_SP_PROG, 1'b0, 1'b0, 1'b1, 20'h0_FF84, 16'h0000, 3'h1);
        $display("t_rw finished");
    endtask
    task automatic t_wait();
        {mode, lag} = {2'h1, 8'hFF};
        for (int n = 0; n < 2; n++) begin
            access(XMB_SP_DATA, 1'b0, 1'b0, 1'b0, 20'h0_0011, 16'h0000, 3'(n));
            check("latency", lat, n + 2);
        end
        lag = 8'h0C;
        access(XMB_SP_DATA, 1'b0, 1'b0, 1'b0, 20'h0_0011, 16'h0000, 3'h3);
        check("late ready", lat > 12, 1'b1);
        mode = 2'h0;
        access(XMB_SP_DATA, 1'b0, 1'b0, 1'b0, 20'h0_0011, 16'h0000, 3'h3);
        rl = lat;
        check("wait count", lat, 6);
        mode = 2'h2;
        access(XMB_SP_DATA, 1'b0, 1'b0, 1'b0, 20'h0_0011, 16'h0000, 3'h3);
        check("wait-done as ready", lat, rl + 1);
        mode = 2'h0;
        $display("t_wait finished");
    endtask
    task automatic t_hold();
        hold_req_n_i = 1'b0;
        tick(4);
        check("grant", bus_grant_n_o, 1'b0);
        check("float", {addr_oe_o, data_oe_o}, 2'h0);
        req_i = 1'b1;
        tick(6);
        check("refused", memory_strobe_n_o, 1'b1);
        hold_req_n_i = 1'b1;
        lat = 0;
        while (done_o !== 1'b1 && lat < 20) begin
            tick(1);
            lat++;
        end
        check("after hold", {done_o, bus_grant_n_o}, 2'h3);
        req_i = 1'b0;
        $display("t_hold finished");
    endtask
    task automatic t_off();
        logic clk_seen;
        {test_reset_i, outputs_off_n_i} = 2'h0;
        tick(5);
        check("off needs emulation_pin_zero", ctrl_oe_o, 1'b1);
        emulation_pin_zero_i = 1'b1;
        tick(5);
        check("off", {ctrl_oe_o, addr_oe_o, data_oe_o}, 3'h0);
        outputs_off_n_i = 1'b1;
        tick(5);
        check("on", ctrl_oe_o, 1'b1);
        check("keeper reset", data_keep_o, 1'b0);
        bus_keeper_enable_i = 1'b1;
        tick(3);
        check("keeper", data_keep_o, 1'b1);
        clk_seen = machine_clock_out_o;
        tick(1);
        check("clock out", machine_clock_out_o, !clk_seen);
        $display("t_off finished");
    endtask
    initial begin
        {rstn_i, req_i, write_i, fetch_i, vector_i, bus_keeper_enable_i} = '0;
        {hold_req_n_i, test_reset_i, emulation_pin_zero_i} = 3'h6;
        outputs_off_n_i = 1'b1;
        space_i = XMB_SP_PROG;
        {addr_i, wdata_i, wait_states_i, mode, lag} = '0;
        tick(5);
        check("reset selects", {program_space_select_n_o, data_space_select_n_o,
            io_space_select_n_o, memory_strobe_n_o, io_strobe_n_o},
            5'h1F);
        check("reset oe", {addr_oe_o, data_oe_o, data_keep_o}, 3'h0);
        rstn_i = 1'b1;
        t_rw();
        t_wait();
        t_hold();
        t_off();
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
